/* File: smpr_pkg.sv */
/*
  package for the signal monitor peak/result register slice: offsets, field
  positions, reset values and widths.
  assumes a byte-wide register port with 10-bit addresses.
*/
package smpr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFS_PERIOD_BYTE0 = 10'h271;
  localparam logic [9:0] OFS_PERIOD_BYTE1 = 10'h272;
  localparam logic [9:0] OFS_PERIOD_BYTE2 = 10'h273;
  localparam logic [9:0] OFS_RESULT_CONTROL = 10'h274;
  localparam logic [9:0] OFS_RESULT_BYTE0 = 10'h275;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_UPDATE_BIT = 4;
  localparam int CTRL_SELECT_BIT = 0;
  localparam logic [7:0] RST_PERIOD_BYTE0 = 8'h80;
  localparam logic [7:0] RST_PERIOD_BYTE1 = 8'h00;
  localparam logic [7:0] RST_PERIOD_BYTE2 = 8'h00;
  localparam logic [7:0] RST_RESULT_CONTROL = 8'h01;
  localparam int PERIOD_W = 24;
  localparam int PEAK_W = 13;
  localparam int RESULT_W = 20;
  localparam int PEAK_LSB = 7;

endpackage : smpr_pkg

/* File: smpr_regs.sv */
/*
  signal monitor register slice: 24-bit period, result control with
  self-clearing update and source select, peak detector and low result byte.
  assumes ref_clk_i is the decimated output clock, peak_mag_i is synchronous
  magnitude data, and a single-cycle strobe register port.
  limitation: an update copies the peak of the last completed period, never
  the period still running, so a fresh value needs one full period first.
*/
// How it works
// [R01] period is 24 bits in output clocks; bytes 1 and 2 reset to zero
// [R02] writing one to control bit 4 snapshots results; the bit self-clears
// [R03] control bit 0 selects source; one means peak detector; resets to 0x01
// [R04] peak source puts 13-bit peak in result 19:7, zeros in 6:0
// [R05] result registers are read-only and change only on an update request
// [R06] peak tracks maximum per period and restarts when the period expires
`timescale 1ns/1ps

module smpr_regs
  import smpr_pkg::*;
#(
  parameter int PEAK_WIDTH = PEAK_W
)
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [smpr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [PEAK_WIDTH-1:0] peak_mag_i,
  input wire logic peak_en_i,
  output logic [smpr_pkg::RESULT_W-1:0] result_o,
  output logic period_done_o
);
  import smpr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] period0;
    logic [7:0] period1;
    logic [7:0] period2;
    logic select;
    logic update;
    logic [PERIOD_W-1:0] count;
    logic [PEAK_WIDTH-1:0] peak;
    logic [PEAK_WIDTH-1:0] peak_held;
    logic [RESULT_W-1:0] result;
    logic [7:0] rdata;
    logic done;
  } smpr_state_s;

  smpr_state_s r;
  smpr_state_s next_r;

  function automatic logic [RESULT_W-1:0] smpr_pack_result(
    input logic sel,
    input logic [PEAK_WIDTH-1:0] pk
  );
    logic [RESULT_W-1:0] v;
    v = '0;
    if (sel)
    begin
      v[PEAK_LSB +: PEAK_WIDTH] = pk; // [R04]
    end
    return v;
  endfunction : smpr_pack_result

  // ****************************************
  // helpers
  // ****************************************
  // the tracker compares magnitudes both inside and at the end of a period
  function automatic logic [PEAK_WIDTH-1:0] smpr_larger(
    input logic [PEAK_WIDTH-1:0] a,
    input logic [PEAK_WIDTH-1:0] b
  );
    logic [PEAK_WIDTH-1:0] m;
    m = b;
    if (a > b)
    begin
      m = a;
    end
    return m;
  endfunction : smpr_larger

  // a disabled detector sees silence, so its held peak decays to zero
  function automatic logic [PEAK_WIDTH-1:0] smpr_gate(
    input logic en,
    input logic [PEAK_WIDTH-1:0] pk
  );
    logic [PEAK_WIDTH-1:0] m;
    m = '0;
    if (en)
    begin
      m = pk;
    end
    return m;
  endfunction : smpr_gate

  // the three period bytes form one length, used as soon as a byte is written
  function automatic logic [PERIOD_W-1:0] smpr_period_of(
    input smpr_state_s s
  );
    logic [PERIOD_W-1:0] p;
    p = {s.period2, s.period1, s.period0}; // [R01]
    return p;
  endfunction : smpr_period_of

  // zero and one both end a period every cycle; the compare is >= so a
  // period shrunk below the running count ends at once instead of wrapping
  function automatic logic smpr_period_end(
    input logic [PERIOD_W-1:0] cnt,
    input logic [PERIOD_W-1:0] len
  );
    logic hit;
    hit = 1'b0;
    if (len == '0)
    begin
      hit = 1'b1;
    end
    else if (cnt >= len - 24'h000001)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction : smpr_period_end

  // the counter restarts at zero when a period ends
  function automatic logic [PERIOD_W-1:0] smpr_count_next(
    input logic [PERIOD_W-1:0] cnt,
    input logic hit
  );
    logic [PERIOD_W-1:0] c;
    c = '0;
    if (!hit)
    begin
      c = cnt + 24'h000001;
    end
    return c;
  endfunction : smpr_count_next

  function automatic logic [7:0] smpr_ctrl_image(
    input logic upd,
    input logic sel
  );
    logic [7:0] b;
    b = 8'h00;
    b[CTRL_UPDATE_BIT] = upd; // [R02]
    b[CTRL_SELECT_BIT] = sel; // [R03]
    return b;
  endfunction : smpr_ctrl_image

  // unmapped addresses read as zero
  function automatic logic [7:0] smpr_read_byte(
    input smpr_state_s s,
    input logic [ADDR_W-1:0] a
  );
    logic [7:0] b;
    b = 8'h00;
    case (a)
      OFS_PERIOD_BYTE0:
      begin
        b = s.period0;
      end
      OFS_PERIOD_BYTE1:
      begin
        b = s.period1; // [R01]
      end
      OFS_PERIOD_BYTE2:
      begin
        b = s.period2; // [R01]
      end
      OFS_RESULT_CONTROL:
      begin
        b = smpr_ctrl_image(s.update, s.select); // [R02] [R03]
      end
      OFS_RESULT_BYTE0:
      begin
        b = s.result[7:0]; // [R04]
      end
      default:
      begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction : smpr_read_byte

  // the result byte is read-only, so a write to it falls into the default
  function automatic smpr_state_s smpr_apply_write(
    input smpr_state_s s,
    input logic [ADDR_W-1:0] a,
    input logic [7:0] d
  );
    smpr_state_s n;
    n = s;
    case (a)
      OFS_PERIOD_BYTE0:
      begin
        n.period0 = d;
      end
      OFS_PERIOD_BYTE1:
      begin
        n.period1 = d; // [R01]
      end
      OFS_PERIOD_BYTE2:
      begin
        n.period2 = d; // [R01]
      end
      OFS_RESULT_CONTROL:
      begin
        n.select = d[CTRL_SELECT_BIT]; // [R03]
        n.update = d[CTRL_UPDATE_BIT]; // [R02]
      end
      default:
      begin
        n = s; // [R05]
      end
    endcase
    return n;
  endfunction : smpr_apply_write

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [PERIOD_W-1:0] period;
    logic expire;
    logic [PEAK_WIDTH-1:0] mag;
    period = smpr_period_of(r); // [R01]
    expire = smpr_period_end(r.count, period);
    mag = smpr_gate(peak_en_i, peak_mag_i);
    next_r = r;

    // pulses and the update request live for one cycle only
    next_r.done = 1'b0;
    next_r.update = 1'b0; // [R02]
    next_r.count = smpr_count_next(r.count, expire);

    // peak tracking restarts at each period end; the finished peak is held
    if (expire)
    begin
      next_r.peak_held = smpr_larger(mag, r.peak);
      next_r.peak = '0; // [R06]
      next_r.done = 1'b1;
    end
    else
    begin
      next_r.peak = smpr_larger(mag, r.peak); // [R06]
    end

    // the snapshot uses the held peak so a read never sees a partial period
    if (r.update)
    begin
      next_r.result = smpr_pack_result(r.select, r.peak_held); // [R02] [R05]
    end

    // writes land after the self-clear, so a repeated update keeps bit 4 set
    if (wr_i)
    begin
      next_r = smpr_apply_write(next_r, addr_i, wdata_i);
    end

    // read data stand for one cycle only, then fall back to zero
    next_r.rdata = 8'h00;
    if (rd_i)
    begin
      next_r.rdata = smpr_read_byte(r, addr_i);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      r.period0 <= RST_PERIOD_BYTE0;
      r.period1 <= RST_PERIOD_BYTE1; // [R01]
      r.period2 <= RST_PERIOD_BYTE2; // [R01]
      r.select <= RST_RESULT_CONTROL[CTRL_SELECT_BIT]; // [R03]
      r.update <= RST_RESULT_CONTROL[CTRL_UPDATE_BIT];
      r.count <= '0;
      r.peak <= '0;
      r.peak_held <= '0;
      r.result <= '0;
      r.rdata <= 8'h00;
      r.done <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o = r.rdata;
  assign result_o = r.result;
  assign period_done_o = r.done;

endmodule : smpr_regs

/* File: smpr_regs_props.sv */
/* checker for smpr_regs port behaviour.
   assumes ref_clk_i and active-low nrst_i. */
`timescale 1ns/1ps
module smpr_chk
  import smpr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [smpr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [smpr_pkg::RESULT_W-1:0] result_o
);
  // ****
  // checks
  // ****
  logic upd;
  logic rdc;
  assign upd = wr_i && addr_i == OFS_RESULT_CONTROL && wdata_i[4];
  assign rdc = rd_i && addr_i == OFS_RESULT_CONTROL;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_set; upd ##1 rdc |=> rdata_o[4]; endproperty
  a_set: assert property (p_set) else $error("update bit lost");
  property p_clr; rdc && !$past(wr_i) |=> !rdata_o[4]; endproperty
  a_clr: assert property (p_clr) else $error("update bit stuck");
  property p_zero; rdc |=> rdata_o[7:5] == 3'h0 && rdata_o[3:1] == 3'h0; endproperty
  a_zero: assert property (p_zero) else $error("control spare bits set");
  property p_low; result_o[6:0] == 7'h0; endproperty
  a_low: assert property (p_low) else $error("result low bits set");
  property p_hold; $changed(result_o) |-> $past(upd, 2); endproperty
  a_hold: assert property (p_hold) else $error("result moved alone");
  property p_ro;
    wr_i && addr_i == OFS_RESULT_BYTE0 && !$past(upd) |=> $stable(result_o);
  endproperty
  a_ro: assert property (p_ro) else $error("result byte took a write");
endmodule : smpr_chk
bind smpr_regs smpr_chk chk (.*);

/* File: test_signal_monitor_peak_result_regs.sv */
/* bench for smpr_regs.
   assumes smpr_pkg and the bound checker. */
`timescale 1ns/1ps
module test_signal_monitor_peak_result_regs;
  import smpr_pkg::*;
  logic ref_clk_i = 1'h0, nrst_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, peak_en_i = 1'h0;
  logic [9:0] addr_i = 10'h0;
  logic [7:0] wdata_i = 8'h0, rdata_o;
  logic [12:0] peak_mag_i = 13'h0, v, w;
  logic [19:0] result_o, gap = 20'h0;
  logic period_done_o, seen = 1'h0, per_on = 1'h0, rd_seen = 1'h0;
  logic [7:0] q[$];
  int fail_count = 0, n_tests = 0, seed = 32'h5C68429F;
  always #2.5 ref_clk_i = ~ref_clk_i;
  smpr_regs dut (.*);
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // read expects d one cycle later
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    wr_i <= wr;
    rd_i <= !wr;
    addr_i <= a;
    wdata_i <= d;
    if (!wr) q.push_back(d);
    @(posedge ref_clk_i);
  endtask : bus
  task idle(input int n);
    wr_i <= 1'h0;
    rd_i <= 1'h0;
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  task end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk_i)
  begin
    if (rd_seen) chk({12'h0, rdata_o}, {12'h0, q.pop_front()});
    rd_seen = rd_i;
    gap = gap + 20'h1;
    if (period_done_o)
    begin
      if (seen) chk(gap, 20'h10);
      seen = per_on;
      gap = 20'h0;
    end
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    peak_en_i <= 1'h1;
    bus(0, OFS_PERIOD_BYTE1, 8'h0);
    bus(0, OFS_PERIOD_BYTE2, 8'h0);
    bus(0, OFS_RESULT_CONTROL, 8'h01);
    bus(0, 10'h3FF, 8'h0);
    bus(1, OFS_PERIOD_BYTE2, 8'h5A);
    bus(0, OFS_PERIOD_BYTE2, 8'h5A);
    bus(1, OFS_RESULT_BYTE0, 8'hFF);
    bus(1, OFS_PERIOD_BYTE2, 8'h0);
    bus(1, OFS_PERIOD_BYTE0, 8'h10);
    repeat (40)
    begin
      peak_mag_i <= 13'($random(seed));
      idle(1);
    end
    per_on <= 1'h1;
    v = 13'($random(seed)) | 13'h1001;
    w = 13'($random(seed)) & 13'h0FFE;
    peak_mag_i <= v;
    idle(40);
    bus(1, OFS_RESULT_CONTROL, 8'h11);
    idle(2);
    bus(0, OFS_RESULT_BYTE0, {v[0], 7'h0});
    chk(result_o, {v, 7'h0});
    peak_mag_i <= w;
    idle(40);
    chk(result_o, {v, 7'h0});
    bus(1, OFS_RESULT_CONTROL, 8'h11);
    bus(0, OFS_RESULT_CONTROL, 8'h11);
    bus(0, OFS_RESULT_CONTROL, 8'h01);
    idle(2);
    chk(result_o, {w, 7'h0});
    bus(1, OFS_RESULT_CONTROL, 8'h10);
    bus(0, OFS_RESULT_CONTROL, 8'h10);
    idle(2);
    chk(result_o, 20'h0);
    end_of_test();
  end
  initial
  begin
    #10000;
    fail_count++;
    end_of_test();
  end
endmodule : test_signal_monitor_peak_result_regs
